// ### shared/rpf_pkg.sv
// Shared constants, states and beat carrier for the packet fragmentation framer
package rpf_pkg;
   // Clock rate
   localparam int CLK_MHZ = 50;
   // Payload limits in bytes
   localparam logic [7:0] MTU_BYTES = 8'h1a;
   localparam logic [7:0] FRAG_MAX_BYTES = 8'hf0;
   localparam logic [7:0] FRAG_DATA_BYTES = 8'h19;
   localparam int MEM_DEPTH = int'(FRAG_MAX_BYTES);
   // Configuration flag byte fields
   localparam int CFG_FRAG_BIT = 1;
   localparam int CFG_IND_BIT = 3;
   // Radio frame header byte fields
   localparam int HDR_FRAG_BIT = 7;
   localparam int HDR_LAST_BIT = 6;
   localparam int IDX_W = 4;
   // Response status codes
   localparam logic [7:0] STATUS_OK = 8'h00;
   localparam logic [7:0] STATUS_TOO_LONG = 8'h01;
   // Gap between fragments and reassembly timeout
   localparam int FRAG_GAP_US = 2;
   localparam int FRAG_GAP_CYC = FRAG_GAP_US * CLK_MHZ;
   localparam int RX_TIMEOUT_US = 50000;
   localparam int RX_TIMEOUT_CYC = RX_TIMEOUT_US * CLK_MHZ;
   // One byte of a stream with its end marker
   typedef struct packed {
      logic last;
      logic [7:0] data;
   } rpf_beat_t;
   // Sender states
   typedef enum logic [2:0] {
      RPF_TX_COLLECT = 3'b000,
      RPF_TX_HDR = 3'b001,
      RPF_TX_DATA = 3'b010,
      RPF_TX_GAP = 3'b011,
      RPF_TX_RESP = 3'b100
   } rpf_tx_state_t;
   // Receiver states
   typedef enum logic [1:0] {
      RPF_RX_HDR = 2'b00,
      RPF_RX_DATA = 2'b01,
      RPF_RX_SKIP = 2'b10,
      RPF_RX_DLV = 2'b11
   } rpf_rx_state_t;
endpackage

// ### hw/rpf_reasm.sv
// Receive side: fragment check, reassembly, timeout and delivery to host
`timescale 1ns/1ps
module rpf_reasm #(
   parameter int TIMEOUT_CYC = rpf_pkg::RX_TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Mode
   input wire logic i_frag_en,
   input wire logic i_ind_en,
   // Radio frames in
   input wire logic i_air_valid,
   input wire rpf_pkg::rpf_beat_t i_air_beat,
   input wire logic i_air_err,
   output logic o_air_ready,
   // Host side
   output logic o_dlv_valid,
   output rpf_pkg::rpf_beat_t o_dlv_beat,
   input wire logic i_dlv_ready,
   output logic o_frag_ind,
   output logic o_drop
);
   localparam logic [31:0] TMO_LOAD = 32'(TIMEOUT_CYC - 1);

   typedef struct packed {
      rpf_pkg::rpf_rx_state_t state;
      logic [rpf_pkg::MEM_DEPTH-1:0][7:0] mem;
      logic [7:0] len;
      logic [7:0] pos;
      logic [7:0] hdr;
      logic [rpf_pkg::IDX_W-1:0] expect_idx;
      logic pending;
      logic bad;
      logic [31:0] timer;
      rpf_pkg::rpf_beat_t beat;
      logic ind;
      logic drop;
   } rpf_rx_regs_t;

   rpf_rx_regs_t st;
   rpf_rx_regs_t nx;
   logic is_frag;

   assign is_frag = i_air_beat.data[rpf_pkg::HDR_FRAG_BIT];

   // Next state of the receiver
   always_comb begin
      nx = st;
      nx.ind = 1'b0;
      nx.drop = 1'b0;
      case (st.state)
         rpf_pkg::RPF_RX_HDR: begin
            if (st.pending) begin
               if (st.timer == 32'h0) begin
                  nx.pending = 1'b0;
                  nx.len = 8'h00;
                  nx.drop = 1'b1;
               end else begin
                  nx.timer = st.timer - 32'h1;
               end
            end
            if (i_air_valid) begin
               nx.hdr = i_air_beat.data;
               nx.bad = 1'b0;
               nx.state = rpf_pkg::RPF_RX_DATA;
               if (i_air_beat.last) begin
                  nx.state = rpf_pkg::RPF_RX_HDR;
                  nx.drop = 1'b1;
               end else if (is_frag && !i_frag_en) begin
                  nx.state = rpf_pkg::RPF_RX_SKIP;
                  nx.drop = 1'b1;
               end else if (is_frag) begin
                  if (i_air_beat.data[rpf_pkg::IDX_W-1:0] == '0) begin
                     nx.drop = nx.drop | nx.pending;
                     nx.len = 8'h00;
                     nx.expect_idx = '0;
                  end else if (!nx.pending ||
                     i_air_beat.data[rpf_pkg::IDX_W-1:0] != st.expect_idx) begin
                     nx.state = rpf_pkg::RPF_RX_SKIP;
                     nx.drop = 1'b1;
                     nx.pending = 1'b0;
                     nx.len = 8'h00;
                  end
               end else begin
                  nx.drop = nx.drop | nx.pending;
                  nx.pending = 1'b0;
                  nx.len = 8'h00;
               end
            end
         end
         rpf_pkg::RPF_RX_DATA: begin
            if (i_air_valid) begin
               if (st.len < rpf_pkg::FRAG_MAX_BYTES) begin
                  nx.mem[st.len] = i_air_beat.data;
                  nx.len = st.len + 8'h01;
               end else begin
                  nx.bad = 1'b1;
               end
               if (i_air_beat.last) begin
                  nx.state = rpf_pkg::RPF_RX_HDR;
                  if (i_air_err || nx.bad || (!st.hdr[rpf_pkg::HDR_FRAG_BIT] &&
                     nx.len > rpf_pkg::MTU_BYTES)) begin
                     nx.drop = 1'b1;
                     nx.pending = 1'b0;
                     nx.len = 8'h00;
                  end else if (st.hdr[rpf_pkg::HDR_FRAG_BIT] &&
                     !st.hdr[rpf_pkg::HDR_LAST_BIT]) begin
                     nx.pending = 1'b1;
                     nx.expect_idx = st.hdr[rpf_pkg::IDX_W-1:0] + 1'b1;
                     nx.timer = TMO_LOAD;
                     nx.ind = i_ind_en;
                  end else begin
                     nx.pending = 1'b0;
                     nx.state = rpf_pkg::RPF_RX_DLV;
                     nx.pos = 8'h00;
                     nx.beat.data = nx.mem[0];
                     nx.beat.last = (nx.len == 8'h01);
                  end
               end
            end
         end
         rpf_pkg::RPF_RX_SKIP: begin
            if (i_air_valid && i_air_beat.last) begin
               nx.state = rpf_pkg::RPF_RX_HDR;
            end
         end
         default: begin
            if (i_dlv_ready) begin
               if (st.beat.last) begin
                  nx.state = rpf_pkg::RPF_RX_HDR;
                  nx.len = 8'h00;
               end else begin
                  nx.pos = st.pos + 8'h01;
                  nx.beat.data = st.mem[nx.pos];
                  nx.beat.last = (st.pos + 8'h02 == st.len);
               end
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   // Outputs
   assign o_air_ready = (st.state != rpf_pkg::RPF_RX_DLV);
   assign o_dlv_valid = (st.state == rpf_pkg::RPF_RX_DLV);
   assign o_dlv_beat = st.beat;
   assign o_frag_ind = st.ind;
   assign o_drop = st.drop;
endmodule

// ### hw/rpf_framer.sv
// Packet fragmentation framer top: sender, response and receive path
`timescale 1ns/1ps
// Operation
// - Normal mode accepts payloads up to 26 bytes
// - Fragment mode accepts 240 bytes, sends fragments
// - Deliver reassembled packet only when complete
// - Response only after all fragments sent
// - Indicate each received fragment except the last when enabled
// - Not in fragment mode: drop fragments
// - Lost fragment discards whole packet
// - Flag bit 1 enables fragmentation mode
// - Flag bit 3 enables indications, needs bit 1
module rpf_framer #(
   parameter int GAP_CYC = rpf_pkg::FRAG_GAP_CYC,
   parameter int RX_TIMEOUT_CYC = rpf_pkg::RX_TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Configuration flag byte
   input wire logic [7:0] i_cfg_flags,
   // Host data transmit request and response
   input wire logic i_req_valid,
   input wire rpf_pkg::rpf_beat_t i_req_beat,
   output logic o_req_ready,
   output logic o_rsp_valid,
   output logic [7:0] o_rsp_status,
   // Radio transmit frames
   output logic o_rf_valid,
   output rpf_pkg::rpf_beat_t o_rf_beat,
   input wire logic i_rf_ready,
   // Radio receive frames
   input wire logic i_air_valid,
   input wire rpf_pkg::rpf_beat_t i_air_beat,
   input wire logic i_air_err,
   output logic o_air_ready,
   // Host delivery and indications
   output logic o_dlv_valid,
   output rpf_pkg::rpf_beat_t o_dlv_beat,
   input wire logic i_dlv_ready,
   output logic o_frag_ind,
   output logic o_drop
);
   // Gap counter reload; the gap runs from this value down to zero
   localparam logic [15:0] GAP_LOAD = 16'(GAP_CYC - 1);

   // Whole sender state, registered as one record
   typedef struct packed {
      rpf_pkg::rpf_tx_state_t state;
      logic [rpf_pkg::MEM_DEPTH-1:0][7:0] mem;
      logic [7:0] len;
      logic [7:0] pos;
      logic [7:0] fcnt;
      logic [rpf_pkg::IDX_W-1:0] idx;
      logic [15:0] gap;
      logic too_long;
      logic frag;
      rpf_pkg::rpf_beat_t beat;
      logic rsp;
      logic [7:0] status;
   } rpf_tx_regs_t;

   // Current and next sender state
   rpf_tx_regs_t st;
   rpf_tx_regs_t nx;
   // Mode decode and handshake strobes
   logic frag_en;
   logic ind_en;
   logic [7:0] limit;
   logic req_take;
   logic rf_take;

   // Mode flags
   assign frag_en = i_cfg_flags[rpf_pkg::CFG_FRAG_BIT];
   assign ind_en = frag_en & i_cfg_flags[rpf_pkg::CFG_IND_BIT];
   assign limit = frag_en ? rpf_pkg::FRAG_MAX_BYTES : rpf_pkg::MTU_BYTES;

   // Beats change hands only when both sides agree
   assign req_take = i_req_valid & o_req_ready;
   assign rf_take = o_rf_valid & i_rf_ready;

   // Header beat for the frame starting at byte p
   function automatic rpf_pkg::rpf_beat_t hdr_beat(
      input logic f,
      input logic [rpf_pkg::IDX_W-1:0] i,
      input logic [7:0] p,
      input logic [7:0] n
   );
      rpf_pkg::rpf_beat_t b;
      b = '0;
      b.data[rpf_pkg::HDR_FRAG_BIT] = f;
      b.data[rpf_pkg::HDR_LAST_BIT] = f && (n - p <= rpf_pkg::FRAG_DATA_BYTES);
      b.data[rpf_pkg::IDX_W-1:0] = f ? i : '0;
      return b;
   endfunction

   // Data beat; last ends the packet or a full fragment
   function automatic rpf_pkg::rpf_beat_t data_beat(
      input logic [7:0] d,
      input logic f,
      input logic [7:0] p,
      input logic [7:0] c,
      input logic [7:0] n
   );
      rpf_pkg::rpf_beat_t b;
      logic pkt_end;
      logic frag_end;
      // Packet end always closes the frame; a full fragment only in fragment mode
      pkt_end = (p + 8'h01 == n);
      frag_end = f && (c + 8'h01 == rpf_pkg::FRAG_DATA_BYTES);
      b.data = d;
      b.last = pkt_end || frag_end;
      return b;
   endfunction

   // Next state of the sender
   always_comb begin
      nx = st;
      // Response is a pulse; only the response state raises it
      nx.rsp = 1'b0;
      case (st.state)
         // Gather request bytes; mode is taken with the last one
         rpf_pkg::RPF_TX_COLLECT: begin
            if (req_take) begin
               if (st.len < rpf_pkg::FRAG_MAX_BYTES) begin
                  nx.mem[st.len] = i_req_beat.data;
                  nx.len = st.len + 8'h01;
               end else begin
                  nx.too_long = 1'b1;
               end
               if (i_req_beat.last) begin
                  nx.frag = frag_en;
                  nx.pos = 8'h00;
                  nx.idx = '0;
                  if (nx.too_long || nx.len > limit) begin
                     nx.status = rpf_pkg::STATUS_TOO_LONG;
                     nx.state = rpf_pkg::RPF_TX_RESP;
                  end else begin
                     nx.status = rpf_pkg::STATUS_OK;
                     nx.state = rpf_pkg::RPF_TX_HDR;
                     nx.beat = hdr_beat(frag_en, '0, 8'h00, nx.len);
                  end
               end
            end
         end
         // Header beat waits for the radio
         rpf_pkg::RPF_TX_HDR: begin
            if (rf_take) begin
               nx.state = rpf_pkg::RPF_TX_DATA;
               nx.fcnt = 8'h00;
               nx.beat = data_beat(st.mem[st.pos], st.frag, st.pos, 8'h00, st.len);
            end
         end
         // Payload beats of the current frame
         rpf_pkg::RPF_TX_DATA: begin
            if (rf_take) begin
               nx.pos = st.pos + 8'h01;
               nx.fcnt = st.fcnt + 8'h01;
               if (st.beat.last) begin
                  if (nx.pos == st.len) begin
                     nx.state = rpf_pkg::RPF_TX_RESP;
                  end else begin
                     nx.state = rpf_pkg::RPF_TX_GAP;
                     nx.gap = GAP_LOAD;
                  end
               end else begin
                  nx.beat = data_beat(st.mem[nx.pos], st.frag, nx.pos, nx.fcnt, st.len);
               end
            end
         end
         // Idle gap before the next fragment header
         rpf_pkg::RPF_TX_GAP: begin
            if (st.gap == 16'h0) begin
               nx.idx = st.idx + 1'b1;
               nx.state = rpf_pkg::RPF_TX_HDR;
               nx.beat = hdr_beat(1'b1, nx.idx, st.pos, st.len);
            end else begin
               nx.gap = st.gap - 16'h1;
            end
         end
         // One-cycle response, then ready for the next request
         default: begin
            nx.rsp = 1'b1;
            nx.state = rpf_pkg::RPF_TX_COLLECT;
            nx.len = 8'h00;
            nx.too_long = 1'b0;
         end
      endcase
   end

   // State register
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= nx;
      end
   end

   // Sender outputs
   assign o_req_ready = (st.state == rpf_pkg::RPF_TX_COLLECT);
   assign o_rf_valid = (st.state == rpf_pkg::RPF_TX_HDR) ||
      (st.state == rpf_pkg::RPF_TX_DATA);
   assign o_rf_beat = st.beat;
   assign o_rsp_valid = st.rsp;
   assign o_rsp_status = st.status;

   // Receive path with reassembly
   rpf_reasm #(
      .TIMEOUT_CYC(RX_TIMEOUT_CYC)
   ) u_reasm (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_frag_en(frag_en),
      .i_ind_en(ind_en),
      .i_air_valid(i_air_valid),
      .i_air_beat(i_air_beat),
      .i_air_err(i_air_err),
      .o_air_ready(o_air_ready),
      .o_dlv_valid(o_dlv_valid),
      .o_dlv_beat(o_dlv_beat),
      .i_dlv_ready(i_dlv_ready),
      .o_frag_ind(o_frag_ind),
      .o_drop(o_drop)
   );
endmodule

// ### verif/rpf_framer_assertions.sv
// Concurrent checks on the framer top ports
`timescale 1ns/1ps
module rpf_framer_assertions #(
   parameter int GAP_CYC = rpf_pkg::FRAG_GAP_CYC
) (
   // Watched ports
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_cfg_flags,
   input wire logic o_req_ready,
   input wire logic o_rsp_valid,
   input wire logic [7:0] o_rsp_status,
   input wire logic o_rf_valid,
   input wire rpf_pkg::rpf_beat_t o_rf_beat,
   input wire logic i_rf_ready,
   input wire logic i_air_valid,
   input wire rpf_pkg::rpf_beat_t i_air_beat,
   input wire logic i_air_err,
   input wire logic o_air_ready,
   input wire logic o_dlv_valid,
   input wire rpf_pkg::rpf_beat_t o_dlv_beat,
   input wire logic i_dlv_ready,
   input wire logic o_frag_ind,
   input wire logic o_drop
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // Frame end taken by the radio; gap check assumes GAP_CYC of two or more
   sequence s_rf_end;
      o_rf_valid && i_rf_ready && o_rf_beat.last;
   endsequence
   sequence s_rf_quiet;
      !o_rf_valid [*2];
   endsequence
   property p_rf_gap;
      s_rf_end |=> s_rf_quiet;
   endproperty
   a_rf_gap: assert property (p_rf_gap) else $error("no gap after frame");
   property p_rsp_pulse;
      o_rsp_valid |=> !o_rsp_valid;
   endproperty
   a_rsp_pulse: assert property (p_rsp_pulse) else $error("response too long");
   property p_ok_rsp;
      o_rsp_valid && o_rsp_status == rpf_pkg::STATUS_OK |->
         $past(o_rf_valid && i_rf_ready && o_rf_beat.last, 2);
   endproperty
   a_ok_rsp: assert property (p_ok_rsp) else $error("ok before last beat");
   property p_busy;
      $rose(o_req_ready) |-> o_rsp_valid;
   endproperty
   a_busy: assert property (p_busy) else $error("ready back before response");
   property p_rf_hold;
      o_rf_valid && !i_rf_ready |=> o_rf_valid && $stable(o_rf_beat);
   endproperty
   a_rf_hold: assert property (p_rf_hold) else $error("radio beat changed");
   property p_dlv_hold;
      o_dlv_valid && !i_dlv_ready |=> o_dlv_valid && $stable(o_dlv_beat);
   endproperty
   a_dlv_hold: assert property (p_dlv_hold) else $error("delivery changed");
   property p_air_block;
      $rose(o_dlv_valid) |-> $past(i_air_valid && o_air_ready && i_air_beat.last);
   endproperty
   a_air_block: assert property (p_air_block) else $error("delivery without frame end");
   property p_ind_mode;
      o_frag_ind |-> $past(i_cfg_flags[1] && i_cfg_flags[3]);
   endproperty
   a_ind_mode: assert property (p_ind_mode) else $error("indication not enabled");
   property p_err_drop;
      i_air_valid && o_air_ready && i_air_beat.last && i_air_err |=> o_drop;
   endproperty
   a_err_drop: assert property (p_err_drop) else $error("bad frame kept");
endmodule
bind rpf_framer rpf_framer_assertions #(.GAP_CYC(GAP_CYC)) i_chk (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cfg_flags(i_cfg_flags),
   .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_status(o_rsp_status),
   .o_rf_valid(o_rf_valid), .o_rf_beat(o_rf_beat), .i_rf_ready(i_rf_ready),
   .i_air_valid(i_air_valid), .i_air_beat(i_air_beat), .i_air_err(i_air_err),
   .o_air_ready(o_air_ready), .o_dlv_valid(o_dlv_valid), .o_dlv_beat(o_dlv_beat),
   .i_dlv_ready(i_dlv_ready), .o_frag_ind(o_frag_ind), .o_drop(o_drop));

// ### verif/rpf_peer.sv
// Peer radio model: takes transmitted beats with random stalls
`timescale 1ns/1ps
module rpf_peer (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Frames from the framer
   input wire logic i_valid,
   input wire rpf_pkg::rpf_beat_t i_beat,
   output logic o_ready = 1'b0
);
   logic [8:0] got[$];
   // Ready only some cycles, so beats must wait
   always @(negedge i_clk) begin
      o_ready <= i_rst_n && $urandom_range(2) != 0;
   end
   // Record every accepted beat, fragment or whole frame
   always @(posedge i_clk) begin
      if (i_valid && o_ready) begin
         got.push_back(i_beat);
      end
   end
endmodule

// ### verif/testbench.sv
// Self-checking bench for the packet fragmentation framer
`timescale 1ns/1ps
module testbench;
   logic i_clk = 0, i_rst_n = 0, i_req_valid = 0, i_air_valid = 0, i_air_err = 0;
   logic i_dlv_ready = 1, i_rf_ready, o_req_ready, o_rsp_valid, o_rf_valid;
   logic o_air_ready, o_dlv_valid, o_frag_ind, o_drop;
   logic [7:0] i_cfg_flags = 0, o_rsp_status, rsp;
   rpf_pkg::rpf_beat_t i_req_beat = 0, i_air_beat = 0, o_rf_beat, o_dlv_beat;
   int fails = 0, n_tests = 0, n_ind = 0, n_drop = 0, n_rsp = 0;
   logic [8:0] exp_q[$], got_rx[$], sent[$];
   rpf_framer #(.GAP_CYC(3), .RX_TIMEOUT_CYC(50)) i_rpf_framer (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cfg_flags(i_cfg_flags),
      .i_req_valid(i_req_valid), .i_req_beat(i_req_beat), .o_req_ready(o_req_ready),
      .o_rsp_valid(o_rsp_valid), .o_rsp_status(o_rsp_status),
      .o_rf_valid(o_rf_valid), .o_rf_beat(o_rf_beat), .i_rf_ready(i_rf_ready),
      .i_air_valid(i_air_valid), .i_air_beat(i_air_beat), .i_air_err(i_air_err),
      .o_air_ready(o_air_ready), .o_dlv_valid(o_dlv_valid), .o_dlv_beat(o_dlv_beat),
      .i_dlv_ready(i_dlv_ready), .o_frag_ind(o_frag_ind), .o_drop(o_drop));
   rpf_peer i_rpf_peer (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(o_rf_valid),
      .i_beat(o_rf_beat), .o_ready(i_rf_ready));
   // Clock
   initial begin
      forever #10 i_clk = ~i_clk;
   end
   // Host side stalls on delivery
   always @(negedge i_clk) begin
      i_dlv_ready <= $urandom_range(3) != 0;
   end
   // Output monitors
   always @(posedge i_clk) begin
      if (o_rsp_valid) rsp = o_rsp_status;
      n_rsp += o_rsp_valid;
      n_ind += o_frag_ind;
      n_drop += o_drop;
      if (o_dlv_valid && i_dlv_ready) got_rx.push_back({1'b0, o_dlv_beat.data});
   end
   task automatic chk(string what, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (e !== g) begin
         fails++;
         $display("[FAIL] %s expected %0h seen %0h", what, e, g);
      end
   endtask
   task automatic chk_q(string what, logic [8:0] g[$]);
      chk({what, " count"}, exp_q.size(), g.size());
      foreach (exp_q[j]) chk(what, exp_q[j], j < g.size() ? g[j] : 9'h1ff);
   endtask
   // Expected header beat of the fragment that starts at byte j of n
   function automatic logic [8:0] frag_hdr(int j, int n);
      return {1'b0, 8'h80 | (j + 25 >= n ? 8'h40 : 8'h00) | 8'(j / 25)};
   endfunction
   // Host request of n bytes; expected frames built beside it
   task automatic send(int n, logic [7:0] fl);
      logic [7:0] b;
      bit ok;
      ok = fl[1] ? n <= 240 : n <= 26;
      i_cfg_flags = fl;
      exp_q = {};
      i_rpf_peer.got = {};
      n_rsp = 0;
      for (int j = 0; j < n; j++) begin
         b = 8'($urandom);
         if (ok && fl[1] && j % 25 == 0)
            exp_q.push_back(frag_hdr(j, n));
         if (ok && !fl[1] && j == 0) exp_q.push_back(9'h000);
         if (ok) exp_q.push_back({j == n - 1 || (fl[1] && j % 25 == 24), b});
         @(negedge i_clk);
         i_req_valid = 1;
         i_req_beat = {j == n - 1, b};
         do @(posedge i_clk); while (!o_req_ready);
      end
      @(negedge i_clk);
      i_req_valid = 0;
      i_req_beat = ~i_req_beat;
      for (int k = 0; k < 3000 && n_rsp == 0; k++) @(negedge i_clk);
      chk("responses", 1, n_rsp);
      chk("status", ok ? rpf_pkg::STATUS_OK : rpf_pkg::STATUS_TOO_LONG, rsp);
      chk_q("radio beat", i_rpf_peer.got);
   endtask
   // One received radio frame: header then n random bytes
   task automatic air(logic [7:0] h, int n, bit err);
      for (int j = 0; j <= n; j++) begin
         @(negedge i_clk);
         i_air_valid = 1;
         i_air_beat = {j == n, j ? 8'($urandom) : h};
         i_air_err = err && j == n;
         if (j) sent.push_back({1'b0, i_air_beat.data});
         do @(posedge i_clk); while (!o_air_ready);
      end
      @(negedge i_clk);
      i_air_valid = 0;
      i_air_err = 0;
      i_air_beat = ~i_air_beat;
   endtask
   // Two frames, second after a gap; dl 0 none, 1 both, 2 first only
   task automatic rx(logic [7:0] fl, logic [15:0] hh, int n1, bit err, int gap,
         int ei, int ed, int dl);
      logic [8:0] a[$];
      i_cfg_flags = fl;
      n_ind = 0;
      n_drop = 0;
      got_rx = {};
      sent = {};
      air(hh[15:8], 25, 0);
      a = sent;
      repeat (gap) @(negedge i_clk);
      air(hh[7:0], n1, err);
      exp_q = {};
      if (dl == 2) exp_q = a;
      if (dl == 1) exp_q = sent;
      for (int k = 0; k < 400 && got_rx.size() < exp_q.size(); k++) @(negedge i_clk);
      repeat (4) @(negedge i_clk);
      chk("indications", ei, n_ind);
      chk("drops", ed, n_drop);
      chk_q("delivered", got_rx);
   endtask
   task automatic wrap_up;
      if (fails == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Watchdog, about ten times the expected run
   initial begin
      #600000;
      fails++;
      wrap_up();
   end
   // Main sequence
   initial begin
      void'($urandom(32'h1f6af9da));
      repeat (12) @(negedge i_clk);
      i_rst_n = 1;
      send(26, 8'h00);
      send(26, 8'h08);
      send(27, 8'h00);
      send(240, 8'h02);
      send(241, 8'h0a);
      send(1, 8'h02);
      repeat (4) send($urandom_range(1, 240), 8'($urandom) & 8'h0a);
      rx(8'h0a, 16'h80c1, 10, 0, 0, 1, 0, 1);
      rx(8'h02, 16'h80c1, 10, 0, 0, 0, 0, 1);
      rx(8'h0a, 16'h80c1, 10, 1, 0, 1, 1, 0);
      rx(8'h0a, 16'h80c1, 10, 0, 60, 1, 2, 0);
      rx(8'h08, 16'h80c1, 10, 0, 0, 0, 2, 0);
      rx(8'h0a, 16'h81c1, 10, 0, 0, 0, 2, 0);
      rx(8'h00, 16'h0000, 10, 0, 0, 0, 0, 1);
      rx(8'h00, 16'h0000, 27, 0, 0, 0, 1, 2);
      wrap_up();
   end
endmodule
